// ===== design/usr_regs.vh
// Register map, field positions, reset values and timing counts
`ifndef USR_REGS_VH
`define USR_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define USR_A_RXCS  8'h00
`define USR_A_RXBUF 8'h04
`define USR_A_TXCS  8'h08
`define USR_A_TXBUF 8'h0c
`define USR_A_BAUD  8'h10
`define USR_A_FLAG  8'h14
`define USR_A_IEN   8'h18
// ----------------------------------------
// Receive control and status fields
// ----------------------------------------
`define USR_B_PORT_ENABLE  7
`define USR_B_RX9   6
`define USR_B_SINGLE_RECEIVE_ENABLE  5
`define USR_B_CONTINUOUS_RECEIVE_ENABLE  4
`define USR_B_ADDRESS_DETECT_ENABLE 3
`define USR_B_FRAMING_ERROR_FLAG  2
`define USR_B_OVERRUN_ERROR_FLAG  1
`define USR_B_RECEIVED_NINTH_BIT  0
// ----------------------------------------
// Transmit control and status fields
// ----------------------------------------
`define USR_B_CLOCK_SOURCE_MASTER_SELECT  7
`define USR_B_TX9   6
`define USR_B_TRANSMIT_ENABLE  5
`define USR_B_SYNC  4
`define USR_B_HIGH_SPEED_BAUD_SELECT  2
`define USR_B_SHIFTER_EMPTY_STATUS  1
`define USR_B_TRANSMIT_NINTH_BIT  0
// ----------------------------------------
// Flag and enable register fields
// ----------------------------------------
`define USR_B_RCF   5
`define USR_B_TXF   4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define USR_RXCS_RST 8'h00
`define USR_TXCS_RST 8'h02
`define USR_BYTE_RST 8'h00
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define USR_OVS_MID  4'h7
`define USR_OVS_LAST 4'hf
`define USR_PRE_LAST 2'h3
`define USR_PH_LAST  2'h3
`define USR_LAST9    4'h8
`define USR_LAST8    4'h7
`endif

// ===== design/usr_top.v
// Serial port: async receiver with address detect, sync master transmitter
`timescale 1ns/1ns
`default_nettype none
`include "usr_regs.vh"

module usr_top #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              MCLK,
  input  wire              RESETN,
  // APB slave
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [ADDR_W-1:0] PADDR,
  input  wire [31:0]       PWDATA,
  output wire [31:0]       PRDATA,
  output wire              PREADY,
  output wire              PSLVERR,
  // Serial data line
  input  wire              SERIAL_DATA_IN,
  output wire              SERIAL_DATA_OUT,
  output wire              SERIAL_DATA_OE_N,
  // Shift timing line
  output wire              SHIFT_TIMING_OUT,
  output wire              SHIFT_TIMING_OE_N,
  // Interrupt requests
  output wire              RX_IRQ,
  output wire              TX_IRQ
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam [1:0] RX_IDLE = 2'b00;
  localparam [1:0] RX_STRT = 2'b01;
  localparam [1:0] RX_DATA = 2'b10;
  localparam [1:0] RX_STOP = 2'b11;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function hit;
    input [ADDR_W-1:0] a;
    input [7:0]        o;
    begin
      hit = (a == o[ADDR_W-1:0]);
    end
  endfunction

  function [3:0] last_bit;
    input nine;
    begin
      last_bit = nine ? `USR_LAST9 : `USR_LAST8;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg         port_enable_r;
  reg         nine_bit_receive_select_r;
  reg         single_receive_enable_r;
  reg         continuous_receive_enable_r;
  reg         address_detect_enable_r;
  reg         framing_error_flag_r;
  reg         overrun_error_flag_r;
  reg         received_ninth_bit_r;
  reg         clock_source_master_select_r;
  reg         nine_bit_transmit_select_r;
  reg         transmit_enable_r;
  reg         sync_mode_r;
  reg         high_speed_baud_select_r;
  reg         transmit_ninth_bit_r;
  reg  [7:0]  baud_divisor_r;
  reg  [7:0]  receive_data_buffer_r;
  reg  [7:0]  transmit_data_buffer_r;
  reg         tx_buf_ninth_r;
  reg         tx_full_r;
  reg         tx_full_nxt;
  reg         receive_complete_flag_r;
  reg         receive_interrupt_enable_r;
  reg         transmit_interrupt_enable_r;
  reg  [31:0] prdata_r;
  reg  [7:0]  rd_mux;
  reg  [7:0]  brg_cnt_r;
  reg  [1:0]  pre_r;
  reg         rx_meta_r;
  reg         rx_sync_r;
  reg  [1:0]  rx_st_r;
  reg  [3:0]  rx_sub_r;
  reg  [3:0]  rx_bit_r;
  reg  [8:0]  rx_sh_r;
  reg  [8:0]  tsr_r;
  reg         tx_busy_r;
  reg  [1:0]  tx_ph_r;
  reg  [3:0]  tx_bit_r;
  reg         ck_r;
  wire        acc;
  wire        wr;
  wire        rd;
  wire        mapped;
  wire        brg_tk;
  wire        s16_tk;
  wire        rx_on;
  wire        rx_done;
  wire [7:0]  rx_word;
  wire        rx_ninth;
  wire        rx_keep;
  wire        tx_on;
  wire        tx_load;
  wire        tx_last;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign acc     = PSEL & PENABLE;
  assign wr      = acc & PWRITE;
  assign rd      = acc & ~PWRITE;
  assign mapped  = hit(PADDR, `USR_A_RXCS) | hit(PADDR, `USR_A_RXBUF) |
                   hit(PADDR, `USR_A_TXCS) | hit(PADDR, `USR_A_TXBUF) |
                   hit(PADDR, `USR_A_BAUD) | hit(PADDR, `USR_A_FLAG) |
                   hit(PADDR, `USR_A_IEN);
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & ~mapped;
  assign PRDATA  = prdata_r;

  always @* begin
    rd_mux = 8'h00;
    if (hit(PADDR, `USR_A_RXCS)) begin
      rd_mux = {port_enable_r, nine_bit_receive_select_r,
                single_receive_enable_r, continuous_receive_enable_r,
                address_detect_enable_r, framing_error_flag_r,
                overrun_error_flag_r, received_ninth_bit_r};
    end else if (hit(PADDR, `USR_A_RXBUF)) begin
      rd_mux = receive_data_buffer_r;
    end else if (hit(PADDR, `USR_A_TXCS)) begin
      rd_mux = {clock_source_master_select_r, nine_bit_transmit_select_r,
                transmit_enable_r, sync_mode_r, 1'b0,
                high_speed_baud_select_r, ~tx_busy_r,
                transmit_ninth_bit_r};
    end else if (hit(PADDR, `USR_A_TXBUF)) begin
      rd_mux = transmit_data_buffer_r;
    end else if (hit(PADDR, `USR_A_BAUD)) begin
      rd_mux = baud_divisor_r;
    end else if (hit(PADDR, `USR_A_FLAG)) begin
      rd_mux[`USR_B_RCF] = receive_complete_flag_r;
      rd_mux[`USR_B_TXF] = ~tx_full_r;
    end else if (hit(PADDR, `USR_A_IEN)) begin
      rd_mux[`USR_B_RCF] = receive_interrupt_enable_r;
      rd_mux[`USR_B_TXF] = transmit_interrupt_enable_r;
    end
  end

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      port_enable_r                <= 1'b0;
      nine_bit_receive_select_r    <= 1'b0;
      single_receive_enable_r      <= 1'b0;
      continuous_receive_enable_r  <= 1'b0;
      address_detect_enable_r      <= 1'b0;
      clock_source_master_select_r <= 1'b0;
      nine_bit_transmit_select_r   <= 1'b0;
      transmit_enable_r            <= 1'b0;
      sync_mode_r                  <= 1'b0;
      high_speed_baud_select_r     <= 1'b0;
      transmit_ninth_bit_r         <= 1'b0;
      baud_divisor_r               <= `USR_BYTE_RST;
      receive_interrupt_enable_r   <= 1'b0;
      transmit_interrupt_enable_r  <= 1'b0;
    end else if (wr) begin
      if (hit(PADDR, `USR_A_RXCS)) begin
        port_enable_r               <= PWDATA[`USR_B_PORT_ENABLE];
        nine_bit_receive_select_r   <= PWDATA[`USR_B_RX9];
        single_receive_enable_r     <= PWDATA[`USR_B_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_r <= PWDATA[`USR_B_CONTINUOUS_RECEIVE_ENABLE];
        address_detect_enable_r     <= PWDATA[`USR_B_ADDRESS_DETECT_ENABLE];
      end
      if (hit(PADDR, `USR_A_TXCS)) begin
        clock_source_master_select_r <= PWDATA[`USR_B_CLOCK_SOURCE_MASTER_SELECT];
        nine_bit_transmit_select_r   <= PWDATA[`USR_B_TX9];
        transmit_enable_r            <= PWDATA[`USR_B_TRANSMIT_ENABLE];
        sync_mode_r                  <= PWDATA[`USR_B_SYNC];
        high_speed_baud_select_r     <= PWDATA[`USR_B_HIGH_SPEED_BAUD_SELECT];
        transmit_ninth_bit_r         <= PWDATA[`USR_B_TRANSMIT_NINTH_BIT];
      end
      if (hit(PADDR, `USR_A_BAUD)) begin
        baud_divisor_r <= PWDATA[7:0];
      end
      if (hit(PADDR, `USR_A_IEN)) begin
        receive_interrupt_enable_r  <= PWDATA[`USR_B_RCF];
        transmit_interrupt_enable_r <= PWDATA[`USR_B_TXF];
      end
    end
  end

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  assign brg_tk = port_enable_r & (brg_cnt_r == 8'h00);
  assign s16_tk = high_speed_baud_select_r ? brg_tk :
                  (brg_tk & (pre_r == `USR_PRE_LAST));

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      brg_cnt_r <= 8'h00;
      pre_r     <= 2'h0;
    end else if (!port_enable_r) begin
      brg_cnt_r <= 8'h00;
      pre_r     <= 2'h0;
    end else if (brg_tk) begin
      brg_cnt_r <= baud_divisor_r;
      pre_r     <= pre_r + 2'h1;
    end else begin
      brg_cnt_r <= brg_cnt_r - 8'h01;
    end
  end

  // ----------------------------------------
  // Receive line synchroniser
  // ----------------------------------------
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= SERIAL_DATA_IN;
      rx_sync_r <= rx_meta_r;
    end
  end

  // ----------------------------------------
  // Asynchronous receiver
  // ----------------------------------------
  assign rx_on = port_enable_r & ~sync_mode_r & continuous_receive_enable_r &
                 ~overrun_error_flag_r;

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_st_r  <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end else if (!rx_on) begin
      rx_st_r  <= RX_IDLE;
      rx_sub_r <= 4'h0;
    end else if (s16_tk) begin
      case (rx_st_r)
        RX_IDLE: begin
          rx_sub_r <= 4'h0;
          if (!rx_sync_r) begin
            rx_st_r <= RX_STRT;
          end
        end
        RX_STRT: begin
          if (rx_sub_r == `USR_OVS_MID) begin
            rx_sub_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_st_r  <= rx_sync_r ? RX_IDLE : RX_DATA;
          end else begin
            rx_sub_r <= rx_sub_r + 4'h1;
          end
        end
        RX_DATA: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == `USR_OVS_LAST) begin
            rx_sh_r <= {rx_sync_r, rx_sh_r[8:1]};
            if (rx_bit_r == last_bit(nine_bit_receive_select_r)) begin
              rx_st_r <= RX_STOP;
            end else begin
              rx_bit_r <= rx_bit_r + 4'h1;
            end
          end
        end
        RX_STOP: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == `USR_OVS_LAST) begin
            rx_st_r <= RX_IDLE;
          end
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  assign rx_done  = rx_on & s16_tk & (rx_st_r == RX_STOP) &
                    (rx_sub_r == `USR_OVS_LAST);
  assign rx_word  = nine_bit_receive_select_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_ninth = nine_bit_receive_select_r & rx_sh_r[8];
  assign rx_keep  = ~(address_detect_enable_r & nine_bit_receive_select_r &
                      ~rx_ninth);

  // ----------------------------------------
  // Receive buffer and status
  // ----------------------------------------
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      receive_data_buffer_r   <= `USR_BYTE_RST;
      received_ninth_bit_r    <= 1'b0;
      framing_error_flag_r    <= 1'b0;
      overrun_error_flag_r    <= 1'b0;
      receive_complete_flag_r <= 1'b0;
    end else begin
      if (rd & hit(PADDR, `USR_A_RXBUF)) begin
        receive_complete_flag_r <= 1'b0;
      end
      if (!continuous_receive_enable_r) begin
        framing_error_flag_r <= 1'b0;
        overrun_error_flag_r <= 1'b0;
      end else if (rx_done & rx_keep) begin
        if (receive_complete_flag_r & ~(rd & hit(PADDR, `USR_A_RXBUF))) begin
          overrun_error_flag_r <= 1'b1;
        end else begin
          receive_data_buffer_r   <= rx_word;
          received_ninth_bit_r    <= rx_ninth;
          framing_error_flag_r    <= ~rx_sync_r;
          receive_complete_flag_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  assign tx_on   = port_enable_r & sync_mode_r & clock_source_master_select_r &
                   transmit_enable_r & ~continuous_receive_enable_r &
                   ~single_receive_enable_r;
  assign tx_load = tx_on & ~tx_busy_r & tx_full_r;

  always @* begin
    tx_full_nxt = tx_full_r;
    if (tx_load) begin
      tx_full_nxt = 1'b0;
    end
    if (wr & hit(PADDR, `USR_A_TXBUF)) begin
      tx_full_nxt = 1'b1;
    end
  end

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      transmit_data_buffer_r <= `USR_BYTE_RST;
      tx_buf_ninth_r         <= 1'b0;
      tx_full_r              <= 1'b0;
    end else begin
      tx_full_r <= tx_full_nxt;
      if (wr & hit(PADDR, `USR_A_TXBUF)) begin
        transmit_data_buffer_r <= PWDATA[7:0];
        tx_buf_ninth_r         <= transmit_ninth_bit_r;
      end
    end
  end

  // ----------------------------------------
  // Synchronous master shifter
  // ----------------------------------------
  assign tx_last = (tx_bit_r == last_bit(nine_bit_transmit_select_r));

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tsr_r     <= 9'h000;
      tx_busy_r <= 1'b0;
      tx_ph_r   <= 2'h0;
      tx_bit_r  <= 4'h0;
      ck_r      <= 1'b0;
    end else if (!tx_on) begin
      tx_busy_r <= 1'b0;
      tx_ph_r   <= 2'h0;
      ck_r      <= 1'b0;
    end else if (tx_load) begin
      tsr_r     <= {tx_buf_ninth_r, transmit_data_buffer_r};
      tx_busy_r <= 1'b1;
      tx_ph_r   <= 2'h0;
      tx_bit_r  <= 4'h0;
      ck_r      <= 1'b0;
    end else if (tx_busy_r & brg_tk) begin
      tx_ph_r <= tx_ph_r + 2'h1;
      ck_r    <= (tx_ph_r == 2'h1) | (tx_ph_r == 2'h2);
      if (tx_ph_r == `USR_PH_LAST) begin
        tsr_r <= {1'b0, tsr_r[8:1]};
        if (tx_last) begin
          tx_busy_r <= 1'b0;
        end else begin
          tx_bit_r <= tx_bit_r + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Pins and requests
  // ----------------------------------------
  assign SERIAL_DATA_OUT   = tsr_r[0];
  assign SERIAL_DATA_OE_N  = ~(tx_on & tx_busy_r);
  assign SHIFT_TIMING_OUT  = ck_r;
  assign SHIFT_TIMING_OE_N = ~(port_enable_r & sync_mode_r &
                               clock_source_master_select_r);
  assign RX_IRQ = receive_complete_flag_r & receive_interrupt_enable_r;
  assign TX_IRQ = ~tx_full_r & transmit_interrupt_enable_r;

endmodule // usr_top
`default_nettype wire

// ===== dv/usr_props.sv
// Port-level assertions for the serial port block
`timescale 1ns/1ns
`default_nettype none
module usr_props #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic              MCLK,
  input wire logic              RESETN,
  // APB
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PSLVERR,
  // Sync master lines
  input wire logic              SERIAL_DATA_OUT,
  input wire logic              SERIAL_DATA_OE_N,
  input wire logic              SHIFT_TIMING_OUT,
  input wire logic              SHIFT_TIMING_OE_N,
  // Requests
  input wire logic              RX_IRQ,
  input wire logic              TX_IRQ
);
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  wire acc = PSEL && PENABLE;

  a_read_upper_zero: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_err: assert property (acc && PADDR > 8'h18 |-> PSLVERR)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (acc && PADDR <= 8'h18 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access flagged as error");
  a_rx_read_clear: assert property (acc && !PWRITE && PADDR == 8'h04 |=> !RX_IRQ)
    else $error("receive request held after data read");
  a_rx_mask_gate: assert property (acc && PWRITE && PADDR == 8'h18 && !PWDATA[5] |=> !RX_IRQ)
    else $error("receive request while masked");
  a_tx_mask_gate: assert property (acc && PWRITE && PADDR == 8'h18 && !PWDATA[4] |=> !TX_IRQ)
    else $error("transmit request while masked");
  a_tx_flag_fall: assert property ($fell(TX_IRQ) |->
    $past(acc && PWRITE && (PADDR == 8'h0c || PADDR == 8'h18)))
    else $error("transmit request fell without buffer or enable write");
  a_drive_needs_master: assert property (!SERIAL_DATA_OE_N |-> !SHIFT_TIMING_OE_N)
    else $error("data driven without master clock");
  a_clock_idle_low: assert property (SERIAL_DATA_OE_N && $past(SERIAL_DATA_OE_N)
    |-> !SHIFT_TIMING_OUT)
    else $error("shift clock high while idle");
  a_clock_high_two: assert property ($rose(SHIFT_TIMING_OUT) |=> SHIFT_TIMING_OUT)
    else $error("shift clock high phase too short");
  a_data_hold_high: assert property (SHIFT_TIMING_OUT && $past(SHIFT_TIMING_OUT)
    |-> $stable(SERIAL_DATA_OUT))
    else $error("data changed while shift clock high");
endmodule // usr_props

bind usr_top usr_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// ===== dv/usr_peer.sv
// Serial peer: async sender toward the receiver, sync slave capture
`timescale 1ns/1ns
`default_nettype none
module usr_peer (
  // Clock
  input  wire logic clk,
  // Sync master lines
  input  wire logic sck,
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  // Async line toward receiver
  output var  logic rxd
);
  // ----
  // Capture and send
  // ----
  logic        sck_q = 1'b0;
  logic [17:0] cap = 18'h0;
  int          ncap = 0;
  initial rxd = 1'b1;

  // Slave takes data at each rising shift clock edge
  always @(posedge clk) begin
    sck_q <= sck;
    if (sck && !sck_q && !sdo_oe_n) begin
      cap <= {sdo, cap[17:1]};
      ncap <= ncap + 1;
    end
  end

  // Start bit, data lsb first, stop bit, one idle bit; line idles high
  task automatic send(input logic [8:0] w, input int nb, input logic stp, input int bt);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i+1] = w[i];
    f[nb+1] = stp;
    for (int i = 0; i < nb + 3; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (bt - 1) @(posedge clk);
    end
  endtask
endmodule // usr_peer
`default_nettype wire

// ===== dv/usr_top_tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ns
`default_nettype none
module usr_top_tb;
  // ----
  // Signals
  // ----
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, sdi, sdo, sdo_oe_n, sck, sck_oe_n, rx_irq, tx_irq;
  logic [31:0] rdat;
  logic        serr;
  logic [8:0]  w1, w2;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          bt, dv, n;
  logic [15:0] rst_tab [7] = '{16'h0000, 16'h0400, 16'h0802, 16'h0c00, 16'h1000,
                               16'h1410, 16'h1800};

  always #25 mclk = ~mclk;

  usr_top DUT (.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
    .SERIAL_DATA_OE_N(sdo_oe_n), .SHIFT_TIMING_OUT(sck), .SHIFT_TIMING_OE_N(sck_oe_n),
    .RX_IRQ(rx_irq), .TX_IRQ(tx_irq));
  usr_peer peer (.clk(mclk), .sck(sck), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .rxd(sdi));

  // ----
  // Helpers
  // ----
  function automatic int bit_time(input int d, input logic hs);
    return (hs ? 16 : 64) * (d + 1);
  endfunction
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, rdat);
  endtask
  task automatic rxw(input logic [8:0] w, input int nb, input logic stp, input logic ef);
    peer.send(w, nb, stp, bt);
    repeat (8) @(negedge mclk);
    chk("receive request", {31'h0, ef}, {31'h0, rx_irq});
  endtask
  task automatic wbits(input int k);
    repeat (3000) begin
      @(posedge mclk);
      if (peer.ncap >= k) break;
    end
    repeat (16 * (dv + 1)) @(negedge mclk);
    chk("shifter released", 1, {31'h0, sdo_oe_n});
    chk("bit count", k, peer.ncap);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(38660));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rst_tab[i]) rc(rst_tab[i][15:8], {24'h0, rst_tab[i][7:0]});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 1, {31'h0, serr});
    chk("unmapped data", 0, rdat);
    apb(1'b1, 8'h00, 32'h07);
    rc(8'h00, 32'h00);
    dv = $urandom_range(2, 0);
    bt = bit_time(dv, 1'b1);
    w1 = 9'($urandom);
    w2 = 9'($urandom);
    apb(1'b1, 8'h10, dv);
    rc(8'h10, dv);
    apb(1'b1, 8'h08, 32'h04);
    apb(1'b1, 8'h18, 32'h30);
    @(negedge mclk);
    chk("transmit request", 1, {31'h0, tx_irq});
    apb(1'b1, 8'h18, 32'h20);
    @(negedge mclk);
    chk("transmit masked", 0, {31'h0, tx_irq});
    apb(1'b1, 8'h00, 32'h80);
    rxw(w1, 8, 1'b1, 1'b0);
    apb(1'b1, 8'h00, 32'h90);
    rxw(w1, 8, 1'b1, 1'b1);
    rc(8'h00, 32'h90);
    rc(8'h04, w1[7:0]);
    apb(1'b1, 8'h18, 32'h00);
    rxw(w2, 8, 1'b1, 1'b0);
    rc(8'h14, 32'h30);
    rc(8'h04, w2[7:0]);
    apb(1'b1, 8'h18, 32'h20);
    apb(1'b1, 8'h00, 32'hd8);
    rxw({1'b0, w1[7:0]}, 9, 1'b1, 1'b0);
    rxw({1'b1, w2[7:0]}, 9, 1'b1, 1'b1);
    rc(8'h00, 32'hd9);
    rc(8'h04, w2[7:0]);
    apb(1'b1, 8'h00, 32'hd0);
    rxw({1'b0, w1[7:0]}, 9, 1'b1, 1'b1);
    rc(8'h00, 32'hd0);
    rc(8'h04, w1[7:0]);
    apb(1'b1, 8'h00, 32'h90);
    rxw(w2, 8, 1'b0, 1'b1);
    rc(8'h00, 32'h94);
    rc(8'h04, w2[7:0]);
    rxw(w1, 8, 1'b1, 1'b1);
    rxw(w2, 8, 1'b1, 1'b1);
    rc(8'h00, 32'h92);
    apb(1'b1, 8'h00, 32'h80);
    rc(8'h00, 32'h80);
    rc(8'h04, w1[7:0]);
    apb(1'b1, 8'h08, 32'h00);
    bt = bit_time(dv, 1'b0);
    apb(1'b1, 8'h00, 32'h90);
    rxw(w2, 8, 1'b1, 1'b1);
    rc(8'h04, w2[7:0]);
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b1, 8'h08, 32'hb0);
    @(negedge mclk);
    chk("clock line drive", 0, {31'h0, sck_oe_n});
    n = peer.ncap;
    apb(1'b1, 8'h0c, w1);
    apb(1'b1, 8'h0c, w2);
    rc(8'h14, 32'h00);
    rc(8'h08, 32'hb0);
    wbits(n + 16);
    chk("sync words", {w2[7:0], w1[7:0]}, peer.cap[17:2]);
    rc(8'h08, 32'hb2);
    rc(8'h14, 32'h10);
    apb(1'b1, 8'h08, 32'hf1);
    n = peer.ncap;
    apb(1'b1, 8'h0c, w1);
    wbits(n + 9);
    chk("nine bit word", {1'b1, w1[7:0]}, peer.cap[17:9]);
    apb(1'b1, 8'h08, 32'hb0);
    apb(1'b1, 8'h00, 32'h90);
    n = peer.ncap;
    apb(1'b1, 8'h0c, w2);
    repeat (40) @(negedge mclk);
    chk("blocked transmit", 1, {31'h0, sdo_oe_n});
    apb(1'b1, 8'h00, 32'ha0);
    repeat (40) @(negedge mclk);
    chk("single enable blocks", 1, {31'h0, sdo_oe_n});
    apb(1'b1, 8'h00, 32'h80);
    wbits(n + 8);
    chk("released word", w2[7:0], peer.cap[17:10]);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    chk("reset pins", 3, {30'h0, sdo_oe_n, sck_oe_n});
    foreach (rst_tab[i]) rc(rst_tab[i][15:8], {24'h0, rst_tab[i][7:0]});
    end_sim();
  end
endmodule // usr_top_tb
`default_nettype wire
